// >>> core/rcs_cfg.svh
// Offsets, field positions, reset values and masks of the reset cause registers
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH
`define RCS_OFF_CONTROL 12'h000
`define RCS_OFF_CONTROL_TWO 12'h004
`define RCS_OFF_SUPPLY 12'h008
`define RCS_OFF_SLEEP 12'h00C
`define RCS_BIT_PRIO_IRQ 7
`define RCS_BIT_CFG_MISMATCH 5
`define RCS_BIT_RESET_INSTR 4
`define RCS_BIT_WDT_TIMEOUT 3
`define RCS_BIT_POWERDOWN 2
`define RCS_BIT_POWERON 1
`define RCS_BIT_BROWNOUT 0
`define RCS_BIT_EXT_PIN 7
`define RCS_BIT_SOFT_WDT 5
`define RCS_BIT_SUPPLY_BOR 3
`define RCS_BIT_SUPPLY_POR 2
`define RCS_BIT_BATT_POR 1
`define RCS_BIT_BATT_EXIT 0
`define RCS_BIT_RET_SLEEP 4
`define RCS_BIT_DEEP_WAKE 2
`define RCS_BIT_PM_SLEEP 0
`define RCS_RST_CONTROL 8'h3C
`define RCS_RST_OTHER 8'h00
`define RCS_MASK_CONTROL 8'hBF
`define RCS_MASK_CONTROL_TWO 8'hA0
`define RCS_MASK_SUPPLY 8'h0F
`define RCS_MASK_SLEEP 8'h15
`define RCS_WDT_CFG_SOFT 2'h2
`endif

// >>> core/rcs_pkg.sv
// Types shared by the reset cause register block
package rcs_pkg;
  // Hardware reset and instruction events, one-cycle pulses
  typedef struct packed {
    logic cfg_mismatch;
    logic reset_instr;
    logic wdt_timeout;
    logic watchdog_clear_instr;
    logic sleep_instr;
    logic poweron;
    logic brownout;
    logic master_clear_pin;
    logic supply_brownout;
    logic supply_poweron;
    logic battery_poweron;
    logic battery_exit;
    logic deep_sleep_wake;
  } rcs_events_t;
  // Interrupt priority, power and watchdog controls driven to the rest of the chip
  typedef struct packed {
    logic priority_irq_enable;
    logic watchdog_on;
    logic retention_in_sleep;
    logic progmem_sleep_power;
  } rcs_ctrl_t;
endpackage : rcs_pkg

// >>> core/rcs_regs.sv
// Reset cause and sleep power control registers behind an APB slave
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "rcs_cfg.svh"
module rcs_regs #(
  parameter int ADDR_WIDTH = 12,
  parameter int DATA_WIDTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [DATA_WIDTH-1:0] pwdata,
  input wire logic [DATA_WIDTH/8-1:0] pstrb,
  output logic [DATA_WIDTH-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rcs_pkg::rcs_events_t events,
  input wire logic [1:0] watchdog_config_field,
  input wire logic retention_config_bit,
  input wire logic regulator_enable,
  output rcs_pkg::rcs_ctrl_t ctrl
);

  // Width of every register behind the bus
  localparam int REG_WIDTH = 8;
  // Register index codes from the address decoder
  localparam logic [2:0] IDX_NONE = 3'h0;
  localparam logic [2:0] IDX_CONTROL = 3'h1;
  localparam logic [2:0] IDX_CONTROL_TWO = 3'h2;
  localparam logic [2:0] IDX_SUPPLY = 3'h3;
  localparam logic [2:0] IDX_SLEEP = 3'h4;

  // Refuse bus widths that cannot reach the map or carry a register
  if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) begin : g_addr_check
    $error("rcs_regs: ADDR_WIDTH must lie between 4 and 32");
  end
  if (DATA_WIDTH < REG_WIDTH || DATA_WIDTH % 8 != 0) begin : g_data_check
    $error("rcs_regs: DATA_WIDTH must be a multiple of 8 and at least 8");
  end

  logic [REG_WIDTH-1:0] control;
  logic [REG_WIDTH-1:0] control_two;
  logic [REG_WIDTH-1:0] supply;
  logic [REG_WIDTH-1:0] sleep_ctl;
  logic [REG_WIDTH-1:0] next_control;
  logic [REG_WIDTH-1:0] next_control_two;
  logic [REG_WIDTH-1:0] next_supply;
  logic [REG_WIDTH-1:0] next_sleep_ctl;
  logic [2:0] idx;
  logic setup;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [REG_WIDTH-1:0] wbyte;
  logic wr_control;
  logic wr_control_two;
  logic wr_supply;
  logic wr_sleep;
  logic ret_allowed;
  logic wdt_soft_mode;
  logic clr_poweron;
  logic clr_brownout;
  logic set_timeout;

  // Register index from a byte address; unmapped addresses give none
  function automatic logic [2:0] rcs_decode(input logic [ADDR_WIDTH-1:0] a);
    logic [2:0] r;
    unique case (a)
      ADDR_WIDTH'(`RCS_OFF_CONTROL): r = IDX_CONTROL;
      ADDR_WIDTH'(`RCS_OFF_CONTROL_TWO): r = IDX_CONTROL_TWO;
      ADDR_WIDTH'(`RCS_OFF_SUPPLY): r = IDX_SUPPLY;
      ADDR_WIDTH'(`RCS_OFF_SLEEP): r = IDX_SLEEP;
      default: r = IDX_NONE;
    endcase
    return r;
  endfunction : rcs_decode

  // Write-zero-to-clear merge: a written 0 clears, a written 1 keeps
  function automatic logic rcs_w0c(input logic cur, input logic wr);
    return cur & wr;
  endfunction : rcs_w0c

  // Zero-extended read word for one register; upper bits read 0
  function automatic logic [DATA_WIDTH-1:0] rcs_word(input logic [REG_WIDTH-1:0] v);
    return DATA_WIDTH'(v);
  endfunction : rcs_word

  // Bus phase strobes; writes honour byte lane 0 only
  assign idx = rcs_decode(paddr);
  assign hit = (idx != IDX_NONE);
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pstrb[0] && hit;
  assign rd_en = setup && !pwrite;
  assign wbyte = pwdata[REG_WIDTH-1:0];

  // Per-register write strobes
  assign wr_control = wr_en && (idx == IDX_CONTROL);
  assign wr_control_two = wr_en && (idx == IDX_CONTROL_TWO);
  assign wr_supply = wr_en && (idx == IDX_SUPPLY);
  assign wr_sleep = wr_en && (idx == IDX_SLEEP);

  // Event groups shared by several flags
  assign clr_poweron = events.poweron || events.supply_poweron;
  assign clr_brownout = events.brownout || events.supply_poweron;
  assign set_timeout = events.watchdog_clear_instr || events.sleep_instr;
  // Configuration qualifiers for the soft watchdog and retention select
  assign wdt_soft_mode = (watchdog_config_field == `RCS_WDT_CFG_SOFT);
  assign ret_allowed = !retention_config_bit;

  // Main control next value; hardware events win over software writes
  always_comb begin
    next_control = control;
    if (wr_control) begin
      // Software stores bits 7,5,4,1,0; timeout and powerdown are read-only
      next_control[`RCS_BIT_PRIO_IRQ] = wbyte[`RCS_BIT_PRIO_IRQ];
      next_control[`RCS_BIT_CFG_MISMATCH] = wbyte[`RCS_BIT_CFG_MISMATCH];
      next_control[`RCS_BIT_RESET_INSTR] = wbyte[`RCS_BIT_RESET_INSTR];
      next_control[`RCS_BIT_POWERON] = wbyte[`RCS_BIT_POWERON];
      next_control[`RCS_BIT_BROWNOUT] = wbyte[`RCS_BIT_BROWNOUT];
    end
    if (events.cfg_mismatch) begin
      next_control[`RCS_BIT_CFG_MISMATCH] = 1'b0;
    end
    if (events.reset_instr) begin
      next_control[`RCS_BIT_RESET_INSTR] = 1'b0;
    end
    if (set_timeout) begin
      next_control[`RCS_BIT_WDT_TIMEOUT] = 1'b1;
    end
    if (events.wdt_timeout) begin
      next_control[`RCS_BIT_WDT_TIMEOUT] = 1'b0;
    end
    if (events.watchdog_clear_instr) begin
      next_control[`RCS_BIT_POWERDOWN] = 1'b1;
    end
    if (events.sleep_instr) begin
      next_control[`RCS_BIT_POWERDOWN] = 1'b0;
    end
    if (clr_poweron) begin
      next_control[`RCS_BIT_POWERON] = 1'b0;
    end
    if (clr_brownout) begin
      next_control[`RCS_BIT_BROWNOUT] = 1'b0;
    end
    if (events.poweron) begin
      // Power-up also sets timeout and powerdown flags
      next_control[`RCS_BIT_WDT_TIMEOUT] = 1'b1;
      next_control[`RCS_BIT_POWERDOWN] = 1'b1;
    end
    next_control = next_control & `RCS_MASK_CONTROL;
  end

  // Main control register; a write only stores, it never raises a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= `RCS_RST_CONTROL;
    end else begin
      control <= next_control;
    end
  end

  // Second control next value; pin reset set wins over a clear
  always_comb begin
    next_control_two = control_two;
    if (wr_control_two) begin
      next_control_two[`RCS_BIT_EXT_PIN] = rcs_w0c(control_two[`RCS_BIT_EXT_PIN],
                                                   wbyte[`RCS_BIT_EXT_PIN]);
      next_control_two[`RCS_BIT_SOFT_WDT] = wbyte[`RCS_BIT_SOFT_WDT];
    end
    if (events.master_clear_pin) begin
      next_control_two[`RCS_BIT_EXT_PIN] = 1'b1;
    end
    next_control_two = next_control_two & `RCS_MASK_CONTROL_TWO;
  end

  // Second control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_two <= `RCS_RST_OTHER;
    end else begin
      control_two <= next_control_two;
    end
  end

  // Supply flags next value; hardware sets win over software clears
  always_comb begin
    next_supply = supply;
    if (wr_supply) begin
      // Software clears by writing 0, never sets
      next_supply[`RCS_BIT_SUPPLY_BOR] = rcs_w0c(supply[`RCS_BIT_SUPPLY_BOR],
                                                 wbyte[`RCS_BIT_SUPPLY_BOR]);
      next_supply[`RCS_BIT_SUPPLY_POR] = rcs_w0c(supply[`RCS_BIT_SUPPLY_POR],
                                                 wbyte[`RCS_BIT_SUPPLY_POR]);
      next_supply[`RCS_BIT_BATT_POR] = rcs_w0c(supply[`RCS_BIT_BATT_POR],
                                               wbyte[`RCS_BIT_BATT_POR]);
      next_supply[`RCS_BIT_BATT_EXIT] = rcs_w0c(supply[`RCS_BIT_BATT_EXIT],
                                                wbyte[`RCS_BIT_BATT_EXIT]);
    end
    if (events.supply_brownout) begin
      next_supply[`RCS_BIT_SUPPLY_BOR] = 1'b1;
    end
    if (events.supply_poweron) begin
      next_supply[`RCS_BIT_SUPPLY_POR] = 1'b1;
    end
    if (events.battery_poweron || events.poweron) begin
      next_supply[`RCS_BIT_BATT_POR] = 1'b1;
    end
    if (events.battery_exit) begin
      next_supply[`RCS_BIT_BATT_EXIT] = 1'b1;
    end
    next_supply = next_supply & `RCS_MASK_SUPPLY;
  end

  // Supply flag register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply <= `RCS_RST_OTHER;
    end else begin
      supply <= next_supply;
    end
  end

  // Sleep control next value; retention select writable only when allowed
  always_comb begin
    next_sleep_ctl = sleep_ctl;
    if (wr_sleep) begin
      if (ret_allowed) begin
        next_sleep_ctl[`RCS_BIT_RET_SLEEP] = wbyte[`RCS_BIT_RET_SLEEP];
      end
      next_sleep_ctl[`RCS_BIT_DEEP_WAKE] = rcs_w0c(sleep_ctl[`RCS_BIT_DEEP_WAKE],
                                                   wbyte[`RCS_BIT_DEEP_WAKE]);
      next_sleep_ctl[`RCS_BIT_PM_SLEEP] = wbyte[`RCS_BIT_PM_SLEEP];
    end
    if (events.deep_sleep_wake) begin
      next_sleep_ctl[`RCS_BIT_DEEP_WAKE] = 1'b1;
    end
    next_sleep_ctl = next_sleep_ctl & `RCS_MASK_SLEEP;
  end

  // Sleep control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_ctl <= `RCS_RST_OTHER;
    end else begin
      sleep_ctl <= next_sleep_ctl;
    end
  end

  // Interrupt priority control toward the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.priority_irq_enable <= 1'b0;
    end else begin
      ctrl.priority_irq_enable <= control[`RCS_BIT_PRIO_IRQ];
    end
  end

  // Watchdog enable, honoured only in the soft configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.watchdog_on <= 1'b0;
    end else begin
      ctrl.watchdog_on <= wdt_soft_mode && control_two[`RCS_BIT_SOFT_WDT];
    end
  end

  // Retention in sleep needs the select, the config bit at 0 and the regulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.retention_in_sleep <= 1'b0;
    end else begin
      ctrl.retention_in_sleep <= sleep_ctl[`RCS_BIT_RET_SLEEP] && ret_allowed
                                 && regulator_enable;
    end
  end

  // Program memory bias during sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.progmem_sleep_power <= 1'b0;
    end else begin
      ctrl.progmem_sleep_power <= sleep_ctl[`RCS_BIT_PM_SLEEP];
    end
  end

  // Read data captured in setup, shown with ready in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en) begin
      unique case (idx)
        IDX_CONTROL: prdata <= rcs_word(control);
        IDX_CONTROL_TWO: prdata <= rcs_word(control_two);
        IDX_SUPPLY: prdata <= rcs_word(supply);
        IDX_SLEEP: prdata <= rcs_word(sleep_ctl);
        default: prdata <= '0;
      endcase
    end
  end

  // Zero wait state slave: ready one cycle after every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Error response with ready on an unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !hit;
    end
  end

endmodule : rcs_regs

// >>> tb/rcs_regs_monitor.sv
// Port assertions for the reset cause registers
`timescale 1ns/1ns
module rcs_regs_monitor (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input rcs_pkg::rcs_events_t events,
  input logic [1:0] watchdog_config_field,
  input logic retention_config_bit,
  input logic regulator_enable,
  input rcs_pkg::rcs_ctrl_t ctrl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd0, rd4, quiet;
  logic [31:0] um;
  // Read setups, idle cycles, unused bits per offset
  assign rd0 = psel && !penable && !pwrite && paddr == 12'h000;
  assign rd4 = psel && !penable && !pwrite && paddr == 12'h004;
  assign quiet = !(psel && pwrite) && events == 13'h0000;
  assign um = paddr == 12'h000 ? 32'hFFFFFF40 : paddr == 12'h004 ? 32'hFFFFFF5F :
    paddr == 12'h008 ? 32'hFFFFFFF0 : 32'hFFFFFFEA;
  a_wdt_off: assert property (watchdog_config_field != 2'h2 |=> !ctrl.watchdog_on)
    else $error("watchdog on");
  a_ret_gate: assert property (ctrl.retention_in_sleep |->
    $past(!retention_config_bit && regulator_enable)) else $error("retention");
  a_ext_set: assert property (events.master_clear_pin ##1 quiet ##1 rd4 |=> prdata[7])
    else $error("pin flag");
  a_tmo_clear: assert property (events == 13'h0400 ##1 quiet ##1 rd0 |=> !prdata[3])
    else $error("timeout flag");
  a_sleep_pd: assert property (events == 13'h0100 ##1 quiet ##1 rd0 |=>
    prdata[3:2] == 2'h2) else $error("powerdown flag");
  a_por_clear: assert property (events == 13'h0080 ##1 quiet ##1 rd0 |=>
    prdata[3:0] == 4'hC) else $error("poweron flags");
  a_unused_zero: assert property (pready && !pwrite |-> (prdata & um) == 32'h0)
    else $error("unused bits");
  a_bad_addr: assert property (!rd0 && psel && !penable && !pwrite &&
    paddr > 12'h00C |=> pready && pslverr && prdata == 32'h0) else $error("unmapped");
  // Main scenarios reached
  c_err: cover property (pslverr);
  c_wdt: cover property (ctrl.watchdog_on);
  c_ret: cover property (ctrl.retention_in_sleep);
endmodule : rcs_regs_monitor
bind rcs_regs rcs_regs_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events), .ctrl(ctrl),
  .watchdog_config_field(watchdog_config_field),
  .retention_config_bit(retention_config_bit), .regulator_enable(regulator_enable));

// >>> tb/rcs_regs_tb.sv
// Self-checking bench for the reset cause registers
`timescale 1ns/1ns
`define CK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module rcs_regs_tb;
  typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] x;} rcs_row_t;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic retention_config_bit = 1'h0, regulator_enable = 1'h1, pready, pslverr, er;
  logic [1:0] watchdog_config_field = 2'h2;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] rd;
  rcs_pkg::rcs_events_t events = 13'h0000;
  rcs_pkg::rcs_ctrl_t ctrl;
  int bad_count = 0, check_count = 0;
  rcs_row_t rows [6] = '{'{12'h000, 8'h00, 8'h0C}, '{12'h000, 8'hFF, 8'hBF},
    '{12'h004, 8'hFF, 8'h20}, '{12'h008, 8'hFF, 8'h00}, '{12'h00C, 8'hFF, 8'h11},
    '{12'h010, 8'hFF, 8'h00}};
  rcs_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .ctrl(ctrl),
    .watchdog_config_field(watchdog_config_field),
    .retention_config_bit(retention_config_bit), .regulator_enable(regulator_enable));
  // 25 MHz clock
  initial begin
    forever #20 pclk = ~pclk;
  end
  // One APB transfer; answer taken at the rising edge that sees pready high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    bad_count += (n == 20);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  // Read and compare one register
  task automatic rdc(input logic [11:0] a, input logic [7:0] x);
    xfer(1'h0, a, 8'h00);
    `CK("prdata", x, rd)
  endtask : rdc
  // One-cycle hardware event pulse
  task automatic ev(input rcs_pkg::rcs_events_t e);
    @(posedge pclk);
    events <= e;
    @(posedge pclk);
    events <= 13'h0000;
  endtask : ev
  // Counts and verdict
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Hang guard
  initial begin
    repeat (3000) @(posedge pclk);
    bad_count++;
    summarize();
  end
  // Reset values, table rows, then events and controls
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 4; i++)
      rdc(12'(4 * i), i == 0 ? 8'h3C : 8'h00);
    foreach (rows[i]) begin
      xfer(1'h1, rows[i].a, rows[i].w);
      xfer(1'h0, rows[i].a, 8'h00);
      `CK("data", rows[i].x, rd)
      `CK("error", rows[i].a > 12'h00C, er)
    end
    `CK("ctrl", 4'hF, ctrl)
    watchdog_config_field <= 2'h1;
    retention_config_bit <= 1'h1;
    repeat (3) @(posedge pclk);
    `CK("ctrl", 4'h9, ctrl)
    xfer(1'h1, 12'h00C, 8'h00);
    rdc(12'h00C, 8'h10);
    ev(13'h0020);
    rdc(12'h004, 8'hA0);
    xfer(1'h1, 12'h004, 8'h20);
    rdc(12'h004, 8'h20);
    ev(13'h001E);
    rdc(12'h008, 8'h0F);
    rdc(12'h000, 8'hBC);
    xfer(1'h1, 12'h008, 8'h00);
    rdc(12'h008, 8'h00);
    ev(13'h0400);
    rdc(12'h000, 8'hB4);
    ev(13'h0200);
    rdc(12'h000, 8'hBC);
    ev(13'h0100);
    rdc(12'h000, 8'hB8);
    xfer(1'h1, 12'h000, 8'hFF);
    rdc(12'h000, 8'hBB);
    rdc(12'h00C, 8'h10);
    ev(13'h1840);
    rdc(12'h000, 8'h8A);
    ev(13'h0080);
    rdc(12'h000, 8'h8C);
    rdc(12'h008, 8'h02);
    ev(13'h0001);
    rdc(12'h00C, 8'h14);
    xfer(1'h1, 12'h00C, 8'h10);
    rdc(12'h00C, 8'h10);
    pstrb <= 4'h0;
    xfer(1'h1, 12'h000, 8'h00);
    pstrb <= 4'hF;
    rdc(12'h000, 8'h8C);
    presetn <= 1'h0;
    @(posedge pclk);
    `CK("ctrl", 4'h0, ctrl)
    presetn <= 1'h1;
    rdc(12'h000, 8'h3C);
    rdc(12'h00C, 8'h00);
    summarize();
  end
endmodule : rcs_regs_tb
